/* pkg/ewd_pkg.sv */
/*
  Constants for the extension window decoder: register indices, field
  positions, reset values and decode slot timing.
  Assumes a 20 MHz bus clock and 32-bit Avalon-MM register access.
*/
package ewd_pkg;

  // Register indices; byte address on the bus is four times the index
  localparam logic [7:0] IDX_WIN0_LOWER_BOUND = 8'h44;
  localparam logic [7:0] IDX_WIN0_UPPER_BOUND = 8'h48;
  localparam logic [7:0] IDX_WIN1_LOWER_BOUND = 8'h4C;
  localparam logic [7:0] IDX_WIN1_UPPER_BOUND = 8'h50;
  localparam logic [7:0] IDX_WINDOW_DECODE_ENABLES = 8'h54;
  localparam logic [7:0] IDX_WINDOW_PRIMARY_EXCLUSION = 8'h55;
  localparam logic [7:0] IDX_DOWNSTREAM_SIDE_DECODE_SETUP = 8'h56;

  // Reset values
  localparam logic [31:0] RST_BOUND = 32'h0000_0000;
  localparam logic [7:0] RST_ENABLES = 8'h00;
  localparam logic [7:0] RST_EXCLUSION = 8'h00;
  localparam logic [7:0] RST_DECODE_SETUP = 8'h06;

  // Writable bit masks of the byte-wide controls and the lower bounds
  localparam logic [7:0] MASK_ENABLES = 8'h03;
  localparam logic [7:0] MASK_EXCLUSION = 8'h03;
  localparam logic [7:0] MASK_DECODE_SETUP = 8'h07;
  localparam logic [31:0] MASK_LOWER_BOUND = 32'hFFFF_FFFC;

  // Field positions
  localparam int TYPE_IO_BIT = 1;
  localparam int TYPE_PREFETCH_BIT = 0;
  localparam int SETUP_SUBTRACTIVE_BIT = 0;
  localparam int SETUP_NEGATIVE_BIT = 1;
  localparam int SETUP_SLOW_BIT = 2;

  // Granularity: memory ignores bits 11..0, I/O works on doublewords
  localparam int MEM_GRAIN_BITS = 12;
  localparam int IO_GRAIN_BITS = 2;

  // Claim slots, in clocks after the frame signal first asserts
  localparam int POSITIVE_SLOT = 1;
  localparam int NORMAL_SUB_SLOT = 3;
  localparam int SLOW_SUB_SLOT = 4;

  typedef enum logic [1:0] {
    SEC_IDLE,
    SEC_WAIT,
    SEC_CLAIM,
    SEC_DONE
  } sec_state_type;

endpackage

/* core/ewd_core.sv */
/*
  Extension window decoder of a two-bus bridge: two programmable windows,
  primary positive decode, secondary negative / positive / subtractive
  forwarding, and an Avalon-MM register slave.
  Assumes both bus interfaces are synchronous to clock_i (no resync
  needed) and that the bus address is a byte address.
*/
module ewd_core (
  input wire logic clock_i,
  input wire logic sys_rst_i,
  // Avalon-MM slave
  input wire logic [9:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  // Primary bus address phase
  input wire logic pri_addr_valid_i,
  input wire logic [31:0] pri_addr_i,
  input wire logic pri_is_io_i,
  output logic pri_claim_o,
  output logic pri_claim_prefetch_o,
  // Secondary bus
  input wire logic sec_frame_n_i,
  input wire logic [31:0] sec_addr_i,
  input wire logic sec_is_io_i,
  input wire logic sec_devsel_n_i,
  output logic sec_forward_o,
  output logic sec_subtractive_o
);

  ////////////////////////////////////////////////////////////////////////
  // Window arithmetic

  function automatic logic [31:0] eff_lower(input logic [31:0] lower,
                                            input logic [31:0] upper);
    logic [31:0] r;
    r = lower & ewd_pkg::MASK_LOWER_BOUND;
    if (!upper[ewd_pkg::TYPE_IO_BIT]) begin
      r[ewd_pkg::MEM_GRAIN_BITS-1:0] = '0;
    end
    return r;
  endfunction

  function automatic logic [31:0] eff_upper(input logic [31:0] upper);
    logic [31:0] r;
    r = upper;
    if (upper[ewd_pkg::TYPE_IO_BIT]) begin
      r[ewd_pkg::IO_GRAIN_BITS-1:0] = '1;
    end else begin
      r[ewd_pkg::MEM_GRAIN_BITS-1:0] = '1;
    end
    return r;
  endfunction

  // Address space must agree with window type; the type bits of the
  // upper bound never narrow the range themselves.
  function automatic logic win_hit(input logic [31:0] lower,
                                   input logic [31:0] upper,
                                   input logic [31:0] addr,
                                   input logic is_io);
    logic type_ok;
    type_ok = (upper[ewd_pkg::TYPE_IO_BIT] == is_io);
    return type_ok && (addr >= eff_lower(lower, upper))
                   && (addr <= eff_upper(upper));
  endfunction

  function automatic logic [31:0] merge_bytes(input logic [31:0] old,
                                              input logic [31:0] nw,
                                              input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    return r;
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Register file

  logic [31:0] lower0_r;
  logic [31:0] upper0_r;
  logic [31:0] lower1_r;
  logic [31:0] upper1_r;
  logic [7:0] enables_r;
  logic [7:0] exclusion_r;
  logic [7:0] setup_r;
  logic ack_r;
  logic [31:0] readdata_r;
  logic [7:0] reg_idx;
  logic word_aligned;
  logic req;

  assign reg_idx = avs_address_i[9:2];
  assign word_aligned = (avs_address_i[1:0] == 2'b00);
  assign req = avs_read_i || avs_write_i;
  // One wait cycle, then the answer at the edge where waitrequest is low.
  // A fixed single wait keeps the window compare off the bus path; a
  // request still held after its answer simply starts a new access.
  assign avs_waitrequest_o = req && !ack_r;
  assign avs_readdata_o = readdata_r;

  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      ack_r <= 1'b0;
    end else begin
      ack_r <= req && !ack_r;
    end
  end

  logic wr_take;
  assign wr_take = avs_write_i && ack_r && word_aligned;

  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      lower0_r <= ewd_pkg::RST_BOUND;
      lower1_r <= ewd_pkg::RST_BOUND;
    end else if (wr_take) begin
      if (reg_idx == ewd_pkg::IDX_WIN0_LOWER_BOUND) begin
        lower0_r <= merge_bytes(lower0_r, avs_writedata_i, avs_byteenable_i)
                    & ewd_pkg::MASK_LOWER_BOUND;
      end
      if (reg_idx == ewd_pkg::IDX_WIN1_LOWER_BOUND) begin
        lower1_r <= merge_bytes(lower1_r, avs_writedata_i, avs_byteenable_i)
                    & ewd_pkg::MASK_LOWER_BOUND;
      end
    end
  end

  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      upper0_r <= ewd_pkg::RST_BOUND;
      upper1_r <= ewd_pkg::RST_BOUND;
    end else if (wr_take) begin
      if (reg_idx == ewd_pkg::IDX_WIN0_UPPER_BOUND) begin
        upper0_r <= merge_bytes(upper0_r, avs_writedata_i, avs_byteenable_i);
      end
      if (reg_idx == ewd_pkg::IDX_WIN1_UPPER_BOUND) begin
        upper1_r <= merge_bytes(upper1_r, avs_writedata_i, avs_byteenable_i);
      end
    end
  end

  // Byte-wide controls live in lane 0 only
  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      enables_r <= ewd_pkg::RST_ENABLES;
      exclusion_r <= ewd_pkg::RST_EXCLUSION;
      setup_r <= ewd_pkg::RST_DECODE_SETUP;
    end else if (wr_take && avs_byteenable_i[0]) begin
      case (reg_idx)
        ewd_pkg::IDX_WINDOW_DECODE_ENABLES: begin
          enables_r <= avs_writedata_i[7:0] & ewd_pkg::MASK_ENABLES;
        end
        ewd_pkg::IDX_WINDOW_PRIMARY_EXCLUSION: begin
          exclusion_r <= avs_writedata_i[7:0] & ewd_pkg::MASK_EXCLUSION;
        end
        ewd_pkg::IDX_DOWNSTREAM_SIDE_DECODE_SETUP: begin
          setup_r <= avs_writedata_i[7:0] & ewd_pkg::MASK_DECODE_SETUP;
        end
        default: begin
        end
      endcase
    end
  end

  // Unmapped or misaligned reads return zero
  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      readdata_r <= 32'h0000_0000;
    end else if (avs_read_i && !ack_r) begin
      readdata_r <= 32'h0000_0000;
      if (word_aligned) begin
        case (reg_idx)
          ewd_pkg::IDX_WIN0_LOWER_BOUND: readdata_r <= lower0_r;
          ewd_pkg::IDX_WIN0_UPPER_BOUND: readdata_r <= upper0_r;
          ewd_pkg::IDX_WIN1_LOWER_BOUND: readdata_r <= lower1_r;
          ewd_pkg::IDX_WIN1_UPPER_BOUND: readdata_r <= upper1_r;
          ewd_pkg::IDX_WINDOW_DECODE_ENABLES: readdata_r <= {24'h000000, enables_r};
          ewd_pkg::IDX_WINDOW_PRIMARY_EXCLUSION: readdata_r <= {24'h000000, exclusion_r};
          ewd_pkg::IDX_DOWNSTREAM_SIDE_DECODE_SETUP: readdata_r <= {24'h000000, setup_r};
          default: readdata_r <= 32'h0000_0000;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Primary decode

  logic [1:0] pri_match;
  logic [1:0] pri_incl;
  logic pri_pf;

  assign pri_match[0] = enables_r[0]
                        && win_hit(lower0_r, upper0_r, pri_addr_i, pri_is_io_i);
  assign pri_match[1] = enables_r[1]
                        && win_hit(lower1_r, upper1_r, pri_addr_i, pri_is_io_i);
  assign pri_incl = pri_match & ~exclusion_r[1:0];
  assign pri_pf = (pri_incl[0] && upper0_r[ewd_pkg::TYPE_PREFETCH_BIT])
                  || (pri_incl[1] && upper1_r[ewd_pkg::TYPE_PREFETCH_BIT]);

  // Claim one clock after the address phase; a disabled or excluded
  // window never claims, whatever its range
  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      pri_claim_o <= 1'b0;
      pri_claim_prefetch_o <= 1'b0;
    end else begin
      pri_claim_o <= pri_addr_valid_i && (|pri_incl);
      pri_claim_prefetch_o <= pri_addr_valid_i && pri_pf;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Secondary decode

  logic [1:0] sec_match;
  logic sec_down_hit;
  logic sec_excl_hit;
  logic sec_start;
  logic frame_n_prev_r;

  // Only enabled windows take part on this side
  assign sec_match[0] = enables_r[0]
                        && win_hit(lower0_r, upper0_r, sec_addr_i, sec_is_io_i);
  assign sec_match[1] = enables_r[1]
                        && win_hit(lower1_r, upper1_r, sec_addr_i, sec_is_io_i);
  assign sec_down_hit = |(sec_match & ~exclusion_r[1:0]);
  assign sec_excl_hit = |(sec_match & exclusion_r[1:0]);
  assign sec_start = frame_n_prev_r && !sec_frame_n_i;

  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      frame_n_prev_r <= 1'b1;
    end else begin
      frame_n_prev_r <= sec_frame_n_i;
    end
  end

  // Claim priority: negative decode, then positive decode of excluded
  // windows, then subtractive. A devsel seen in any wait cycle cancels
  // the subtractive claim, since a slow device has taken the cycle.
  // Only one transaction is tracked; a new frame waits for frame high.
  ewd_pkg::sec_state_type sec_state_r;
  logic [2:0] slot_cnt_r;
  logic [2:0] sub_slot_r;
  logic taken_r;

  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      sec_state_r <= ewd_pkg::SEC_IDLE;
      slot_cnt_r <= 3'h0;
      sub_slot_r <= 3'h0;
      sec_forward_o <= 1'b0;
      sec_subtractive_o <= 1'b0;
      taken_r <= 1'b0;
    end else begin
      case (sec_state_r)
        ewd_pkg::SEC_IDLE: begin
          sec_forward_o <= 1'b0;
          sec_subtractive_o <= 1'b0;
          taken_r <= 1'b0;
          slot_cnt_r <= 3'h1;
          if (sec_start) begin
            if (setup_r[ewd_pkg::SETUP_NEGATIVE_BIT]) begin
              if (!sec_down_hit) begin
                sec_forward_o <= 1'b1;
                sec_state_r <= ewd_pkg::SEC_CLAIM;
              end else begin
                sec_state_r <= ewd_pkg::SEC_DONE;
              end
            end else if (sec_excl_hit) begin
              sec_forward_o <= 1'b1;
              sec_state_r <= ewd_pkg::SEC_CLAIM;
            end else if (setup_r[ewd_pkg::SETUP_SUBTRACTIVE_BIT] && !sec_down_hit) begin
              // Slow slot only when both enable and speed bits are set
              sub_slot_r <= setup_r[ewd_pkg::SETUP_SLOW_BIT]
                            ? 3'(ewd_pkg::SLOW_SUB_SLOT)
                            : 3'(ewd_pkg::NORMAL_SUB_SLOT);
              sec_state_r <= ewd_pkg::SEC_WAIT;
            end else begin
              sec_state_r <= ewd_pkg::SEC_DONE;
            end
          end
        end
        ewd_pkg::SEC_WAIT: begin
          slot_cnt_r <= slot_cnt_r + 3'h1;
          if (!sec_devsel_n_i) begin
            taken_r <= 1'b1;
          end
          if (!sec_devsel_n_i || taken_r) begin
            sec_state_r <= ewd_pkg::SEC_DONE;
          end else if (slot_cnt_r == sub_slot_r - 3'h1) begin
            sec_forward_o <= 1'b1;
            sec_subtractive_o <= 1'b1;
            sec_state_r <= ewd_pkg::SEC_CLAIM;
          end
        end
        ewd_pkg::SEC_CLAIM: begin
          // Held until the initiator lets go of the frame
          if (sec_frame_n_i) begin
            sec_forward_o <= 1'b0;
            sec_subtractive_o <= 1'b0;
            sec_state_r <= ewd_pkg::SEC_IDLE;
          end
        end
        ewd_pkg::SEC_DONE: begin
          if (sec_frame_n_i) begin
            sec_state_r <= ewd_pkg::SEC_IDLE;
          end
        end
        default: begin
          sec_state_r <= ewd_pkg::SEC_IDLE;
        end
      endcase
    end
  end

endmodule // ewd_core

/* verification/ewd_checker_sva.sv */
/*
  Port checker for the extension window decoder.
  Assumes binding to ewd_core; one clock and a synchronous high reset.
*/
module ewd_checker (
  input wire logic clock_i,
  input wire logic sys_rst_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic avs_waitrequest_o,
  input wire logic [31:0] avs_readdata_o,
  input wire logic pri_addr_valid_i,
  input wire logic pri_claim_o,
  input wire logic pri_claim_prefetch_o,
  input wire logic sec_frame_n_i,
  input wire logic sec_forward_o,
  input wire logic sec_subtractive_o
);
  default clocking cb @(posedge clock_i);
  endclocking
  default disable iff (sys_rst_i);
  ////////////////////////////////////////////////////////////
  sequence s_frame_start;
    sec_frame_n_i ##1 !sec_frame_n_i;
  endsequence
  sequence s_frame_end;
    sec_forward_o && sec_frame_n_i;
  endsequence
  a_one_wait: assert property (
    (avs_read_i || avs_write_i) && avs_waitrequest_o |=> !avs_waitrequest_o)
    else $error("register access not answered after one wait");
  a_req_stalls: assert property ($rose(avs_read_i) |-> avs_waitrequest_o)
    else $error("read answered without wait");
  a_rdata_holds: assert property (!avs_read_i |=> $stable(avs_readdata_o))
    else $error("read data changed without a read");
  a_claim_cause: assert property (pri_claim_o |-> $past(pri_addr_valid_i))
    else $error("primary claim without address phase");
  a_pf_in_claim: assert property (pri_claim_prefetch_o |-> pri_claim_o)
    else $error("prefetch flag without claim");
  a_sub_with_fwd: assert property (sec_subtractive_o |-> sec_forward_o)
    else $error("subtractive flag without forward");
  a_fwd_release: assert property (
    s_frame_end |=> !sec_forward_o && !sec_subtractive_o)
    else $error("forward held after frame end");
  a_fwd_in_frame: assert property ($rose(sec_forward_o) |-> !$past(sec_frame_n_i))
    else $error("forward raised outside a frame");
  a_sub_slot: assert property (s_frame_start |-> !sec_subtractive_o [*3])
    else $error("subtractive claim before its slot");
endmodule // ewd_checker

/* verification/ewd_bus_model.sv */
/*
  Initiator model for the primary and secondary buses.
  Assumes the testbench calls one task at a time.
*/
module ewd_bus_model (
  input wire logic clock_i,
  input wire logic pri_claim_o,
  input wire logic pri_claim_prefetch_o,
  input wire logic sec_forward_o,
  input wire logic sec_subtractive_o,
  output logic pri_valid_o,
  output logic [31:0] pri_addr_o,
  output logic pri_io_o,
  output logic sec_frame_n_o,
  output logic [31:0] sec_addr_o,
  output logic sec_io_o,
  output logic sec_devsel_n_o
);
  initial begin
    pri_valid_o = 1'b0;
    pri_addr_o = 32'h0;
    pri_io_o = 1'b0;
    sec_frame_n_o = 1'b1;
    sec_addr_o = 32'h0;
    sec_io_o = 1'b0;
    sec_devsel_n_o = 1'b1;
  end
  task automatic pri_cycle(input logic [31:0] a, input logic io, output logic [1:0] res);
    @(posedge clock_i);
    pri_valid_o <= 1'b1;
    pri_addr_o <= a;
    pri_io_o <= io;
    @(posedge clock_i);
    pri_valid_o <= 1'b0;
    // Released address shows garbage, not the old value
    pri_addr_o <= ~a;
    @(negedge clock_i);
    res = {pri_claim_o, pri_claim_prefetch_o};
  endtask
  ////////////////////////////////////////////////////////////
  // Result: first claim clock counted from the frame edge (9 = none),
  // subtractive flag, left-over claim after the frame ends
  task automatic sec_cycle(input logic [31:0] a, input logic io, input logic dv,
                           output logic [5:0] res);
    int k;
    res = 6'h24;
    @(posedge clock_i);
    sec_frame_n_o <= 1'b0;
    sec_addr_o <= a;
    sec_io_o <= io;
    for (k = 0; k < 8; k++) begin
      @(posedge clock_i);
      if (k == 0) sec_addr_o <= ~a;
      if (k == 1 && dv) sec_devsel_n_o <= 1'b0;
      @(negedge clock_i);
      // Seen here, the claim is sampled at the next rising edge
      if (sec_forward_o && res[5:2] == 4'h9) res[5:1] = {4'(k + 1), sec_subtractive_o};
    end
    @(posedge clock_i);
    // Pull-ups return frame and devsel high
    sec_frame_n_o <= 1'b1;
    sec_devsel_n_o <= 1'b1;
    repeat (2) @(posedge clock_i);
    @(negedge clock_i);
    res[0] = sec_forward_o | sec_subtractive_o;
  endtask
endmodule // ewd_bus_model

/* verification/tb.sv */
/*
  Testbench for the extension window decoder: register access over
  Avalon-MM, primary claims and secondary forwarding through the bus model.
  Assumes ewd_checker and ewd_bus_model are compiled first.
*/
bind ewd_core ewd_checker u_ewd_checker (.clock_i(clock_i), .sys_rst_i(sys_rst_i),
  .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
  .avs_waitrequest_o(avs_waitrequest_o), .avs_readdata_o(avs_readdata_o),
  .pri_addr_valid_i(pri_addr_valid_i), .pri_claim_o(pri_claim_o),
  .pri_claim_prefetch_o(pri_claim_prefetch_o), .sec_frame_n_i(sec_frame_n_i),
  .sec_forward_o(sec_forward_o), .sec_subtractive_o(sec_subtractive_o));
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic clock_i, sys_rst_i, avs_read_i, avs_write_i, avs_waitrequest_o;
  logic [9:0] avs_address_i;
  logic [31:0] avs_writedata_i, avs_readdata_o, pa, sa;
  logic pv, pio, pc_o, pp_o, sf_n, sio, sdv_n, sfw, ssub;
  int errors = 0;
  int check_count = 0;
  int i;
  logic [9:0] ctl_addr [3] = '{10'h150, 10'h154, 10'h158};
  logic [7:0] ctl_mask [3] = '{8'h03, 8'h03, 8'h07};
  logic [7:0] ctl_rst [3] = '{8'h00, 8'h00, 8'h06};
  logic [31:0] p_addr [8] = '{32'h1000_0000, 32'h1000_1FFC, 32'h1000_2000, 32'h0FFF_FFFC,
    32'h1000_0000, 32'h0000_010C, 32'h0000_0110, 32'h0000_00FC};
  logic p_io [8] = '{0, 0, 0, 0, 1, 1, 1, 1};
  logic [1:0] p_exp [8] = '{2'b10, 2'b10, 2'b00, 2'b00, 2'b00, 2'b10, 2'b00, 2'b00};
  ewd_core u_ewd_core (.clock_i(clock_i), .sys_rst_i(sys_rst_i),
    .avs_address_i(avs_address_i), .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
    .avs_writedata_i(avs_writedata_i), .avs_byteenable_i(4'hF),
    .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o),
    .pri_addr_valid_i(pv), .pri_addr_i(pa), .pri_is_io_i(pio), .pri_claim_o(pc_o),
    .pri_claim_prefetch_o(pp_o), .sec_frame_n_i(sf_n), .sec_addr_i(sa),
    .sec_is_io_i(sio), .sec_devsel_n_i(sdv_n), .sec_forward_o(sfw),
    .sec_subtractive_o(ssub));
  ewd_bus_model u_ewd_bus_model (.clock_i(clock_i), .pri_claim_o(pc_o),
    .pri_claim_prefetch_o(pp_o), .sec_forward_o(sfw), .sec_subtractive_o(ssub),
    .pri_valid_o(pv), .pri_addr_o(pa), .pri_io_o(pio), .sec_frame_n_o(sf_n),
    .sec_addr_o(sa), .sec_io_o(sio), .sec_devsel_n_o(sdv_n));
  ////////////////////////////////////////////////////////////
  task automatic end_sim();
    $display("checks %0d errors %0d", check_count, errors);
    if (errors == 0 && check_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      errors++;
    end
  endtask
  // Holds the request until waitrequest is seen low; bounded wait
  task automatic bus(input logic w, input logic [9:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    int n;
    n = 0;
    @(posedge clock_i);
    avs_address_i <= a;
    avs_writedata_i <= d;
    avs_read_i <= !w;
    avs_write_i <= w;
    do begin
      @(posedge clock_i);
      n++;
    end while (avs_waitrequest_o !== 1'b0 && n < 20);
    q = avs_readdata_o;
    avs_read_i <= 1'b0;
    avs_write_i <= 1'b0;
    if (n >= 20) begin
      $display("mismatch at %0t: bus timeout", $time);
      errors++;
      end_sim();
    end
  endtask
  task automatic wr(input logic [9:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask
  task automatic rd(input logic [9:0] a, input logic [31:0] exp);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, q);
    chk(q, exp);
  endtask
  task automatic pc(input logic [31:0] a, input logic io, input logic [1:0] exp);
    logic [1:0] r;
    u_ewd_bus_model.pri_cycle(a, io, r);
    chk({30'h0, r}, {30'h0, exp});
  endtask
  task automatic sc(input logic [31:0] a, input logic io, input logic dv,
                    input logic [5:0] exp);
    logic [5:0] r;
    u_ewd_bus_model.sec_cycle(a, io, dv, r);
    chk({26'h0, r}, {26'h0, exp});
  endtask
  ////////////////////////////////////////////////////////////
  initial begin
    clock_i = 1'b0;
    forever #25 clock_i = ~clock_i;
  end
  initial begin
    sys_rst_i = 1'b1;
    avs_read_i = 1'b0;
    avs_write_i = 1'b0;
    avs_address_i = 10'h0;
    avs_writedata_i = 32'h0;
    repeat (5) @(posedge clock_i);
    sys_rst_i <= 1'b0;
    for (i = 0; i < 4; i++) rd(10'h110 + 10'(i * 16), 32'h0);
    for (i = 0; i < 3; i++) rd(ctl_addr[i], {24'h0, ctl_rst[i]});
    for (i = 0; i < 3; i++) begin
      wr(ctl_addr[i], 32'hFFFF_FFFF);
      rd(ctl_addr[i], {24'h0, ctl_mask[i]});
      wr(ctl_addr[i], {24'h0, ctl_rst[i]});
    end
    wr(10'h110, 32'hFFFF_FFFF);
    rd(10'h110, 32'hFFFF_FFFC);
    wr(10'h3FC, 32'h5);
    rd(10'h3FC, 32'h0);
    wr(10'h110, 32'h1000_0ABC);
    wr(10'h120, 32'h1000_1000);
    rd(10'h120, 32'h1000_1000);
    wr(10'h130, 32'h0000_0100);
    wr(10'h140, 32'h0000_010E);
    pc(32'h1000_0000, 1'b0, 2'b00);
    wr(10'h150, 32'h3);
    for (i = 0; i < 8; i++) pc(p_addr[i], p_io[i], p_exp[i]);
    wr(10'h120, 32'h1000_1001);
    pc(32'h1000_0800, 1'b0, 2'b11);
    wr(10'h154, 32'h1);
    pc(32'h1000_0800, 1'b0, 2'b00);
    // Negative decode on: only traffic not sent downstream goes up
    sc(32'h0000_0104, 1'b1, 1'b0, 6'h24);
    sc(32'h2000_0000, 1'b0, 1'b0, 6'h04);
    sc(32'h1000_0800, 1'b0, 1'b0, 6'h04);
    wr(10'h158, 32'h0);
    sc(32'h1000_0800, 1'b0, 1'b0, 6'h04);
    sc(32'h2000_0000, 1'b0, 1'b0, 6'h24);
    wr(10'h150, 32'h2);
    sc(32'h1000_0800, 1'b0, 1'b0, 6'h24);
    wr(10'h158, 32'h5);
    sc(32'h2000_0000, 1'b0, 1'b0, 6'h12);
    sc(32'h2000_0000, 1'b0, 1'b1, 6'h24);
    wr(10'h158, 32'h1);
    sc(32'h2000_0000, 1'b0, 1'b0, 6'h0E);
    wr(10'h158, 32'h4);
    sc(32'h2000_0000, 1'b0, 1'b0, 6'h24);
    // Reset in mid-run must bring the enables and decode setup back to their defaults
    @(posedge clock_i);
    sys_rst_i <= 1'b1;
    repeat (2) @(posedge clock_i);
    sys_rst_i <= 1'b0;
    rd(10'h150, 32'h0);
    rd(10'h158, 32'h6);
    end_sim();
  end
endmodule // tb
